// *** rtl/dma_channel_control.sv ***
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dma_ctl_defs.svh"
// Contract
// - control bit 15 on lets the channel move data, off keeps it idle
// - bit 14 picks byte elements when set, 16-bit words when clear
// - bit 12 set raises block event at half block, clear at full block
// - bit 11 adds a null peripheral write per RAM write; software keeps direction clear
// - bits 5-4 choose post-increment, no-increment, peripheral indirect, or reserved; every value but no-increment post-increments here
// - bits 1-0 choose continuous or one-shot, with or without ping-pong
// - one-shot ping-pong moves one block per buffer then stops
// - control bits 10-6 and 3-2 read zero and ignore writes
// - collision status bits 3-0 flag peripheral write collisions per channel
// - collision bits 15-4 read zero; all flags zero after reset
// - all writable control fields reset to zero
module dma_channel_control #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral side
  input wire logic [NCH-1:0] dma_trig_i,
  input wire logic [NCH-1:0] periph_collision_i,
  // shared memory port
  output dma_ctl_pkg::bus_req_type mem_o,
  input wire logic mem_ready_i,
  input wire logic [15:0] mem_rdata_i,
  // interrupt
  output logic irq_o
);
  logic [NCH-1:0][15:0] ctrl_r;
  logic [NCH-1:0][15:0] cnt_r;
  logic [NCH-1:0][15:0] rama_r;
  logic [NCH-1:0][15:0] pera_r;
  logic [NCH-1:0] coll_r;
  logic [NCH-1:0] stat_r;
  logic [NCH-1:0] mask_r;
  logic [NCH-1:0] restart;
  logic [NCH-1:0] half_ev;
  logic [NCH-1:0] done_ev;
  logic [NCH-1:0] grant;
  logic [NCH-1:0][1:0] trig_sync_r;
  logic [NCH-1:0][1:0] coll_sync_r;
  dma_ctl_pkg::bus_req_type [NCH-1:0] chan_bus;

  // write channel holding
  logic aw_have_r;
  logic w_have_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic [15:0] wval;
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_fire = aw_have_r && w_have_r;
  // only the low two lanes carry register bits
  assign wval = {wstrb_r[1] ? wdata_r[15:8] : 8'h00, wstrb_r[0] ? wdata_r[7:0] : 8'h00};

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_have_r <= 1'b0;
      awaddr_r <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  // decode of the held write address
  logic wr_ok;
  logic [NCH-1:0] wr_ctrl;
  logic [NCH-1:0] wr_cnt;
  logic [NCH-1:0] wr_rama;
  logic [NCH-1:0] wr_pera;
  logic wr_stat;
  logic wr_mask;
  always_comb begin
    wr_ctrl = '0;
    wr_cnt = '0;
    wr_rama = '0;
    wr_pera = '0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    wr_ok = 1'b1;
    if (awaddr_r == `OFF_COLL) begin
      wr_ok = 1'b1;
    end else if (awaddr_r == `OFF_IRQ_STAT) begin
      wr_stat = 1'b1;
    end else if (awaddr_r == `OFF_IRQ_MASK) begin
      wr_mask = 1'b1;
    end else begin
      wr_ok = 1'b0;
      for (int i = 0; i < NCH; i++) begin
        if (awaddr_r == 12'(`OFF_CTRL0 + i * `OFF_CTRL_STRIDE)) begin
          wr_ctrl[i] = 1'b1;
          wr_ok = 1'b1;
        end else if (awaddr_r == 12'(`OFF_CNT0 + i * `OFF_CTRL_STRIDE)) begin
          wr_cnt[i] = 1'b1;
          wr_ok = 1'b1;
        end else if (awaddr_r == 12'(`OFF_RAMA0 + i * `OFF_CTRL_STRIDE)) begin
          wr_rama[i] = 1'b1;
          wr_ok = 1'b1;
        end else if (awaddr_r == 12'(`OFF_PERA0 + i * `OFF_CTRL_STRIDE)) begin
          wr_pera[i] = 1'b1;
          wr_ok = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= {NCH{`CTRL_RST}};
      cnt_r <= '0;
      rama_r <= '0;
      pera_r <= '0;
    end else if (wr_fire) begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_ctrl[i]) begin
          ctrl_r[i] <= wval & `CTRL_WMASK;
        end
        if (wr_cnt[i]) begin
          cnt_r[i] <= wval;
        end
        if (wr_rama[i]) begin
          rama_r[i] <= wval;
        end
        if (wr_pera[i]) begin
          pera_r[i] <= wval;
        end
      end
    end
  end

  // turning a channel on from off reinitialises it
  always_comb begin
    restart = '0;
    for (int i = 0; i < NCH; i++) begin
      restart[i] = wr_fire && wr_ctrl[i] && wval[`BIT_ON] && !ctrl_r[i][`BIT_ON];
    end
  end

  // pins from the peripherals pass two flops first
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trig_sync_r <= '0;
      coll_sync_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        trig_sync_r[i] <= {trig_sync_r[i][0], dma_trig_i[i]};
        coll_sync_r[i] <= {coll_sync_r[i][0], periph_collision_i[i]};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      coll_r <= `COLL_RST;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (coll_sync_r[i][1]) begin
          coll_r[i] <= 1'b1;
        end else if (restart[i]) begin
          coll_r[i] <= 1'b0;
        end
      end
    end
  end

  // event status: set wins over write-one-to-clear
  logic [NCH-1:0] trig_edge_r;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_r <= '0;
      mask_r <= '0;
      trig_edge_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        trig_edge_r[i] <= trig_sync_r[i][1];
      end
      if (wr_fire && wr_mask) begin
        mask_r <= wval[NCH-1:0];
      end
      stat_r <= (stat_r & ~((wr_fire && wr_stat) ? wval[NCH-1:0] : '0)) | half_ev | done_ev;
    end
  end
  assign irq_o = |(stat_r & mask_r);

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    dma_ctl_pkg::chan_cfg_type cfg;
    assign cfg = '{channel_on: ctrl_r[g][`BIT_ON], byte_size: ctrl_r[g][`BIT_SIZE],
                   ram_to_periph: ctrl_r[g][`BIT_DIR], half_irq: ctrl_r[g][`BIT_HALF],
                   null_write_select: ctrl_r[g][`BIT_NULL_WRITE_SELECT],
                   addressing_select: ctrl_r[g][5:4], op_mode: ctrl_r[g][1:0]};
    dma_chan u_chan (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .cfg_i(cfg),
      .count_i(cnt_r[g]),
      .ram_base_i(rama_r[g]),
      .periph_addr_i(pera_r[g]),
      .restart_i(restart[g]),
      .trig_i(trig_sync_r[g][1] && !trig_edge_r[g]),
      .grant_i(grant[g]),
      .rdata_i(mem_rdata_i),
      .bus_o(chan_bus[g]),
      .half_o(half_ev[g]),
      .done_o(done_ev[g]),
      .busy_o()
    );
  end

  dma_bus_arb #(.NCH(NCH)) u_arb (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .req_i(chan_bus),
    .grant_o(grant),
    .bus_o(mem_o),
    .ready_i(mem_ready_i)
  );

  // read channel, one cycle after address
  logic [15:0] rval;
  always_comb begin
    rval = 16'h0000;
    if (s_axi_araddr == `OFF_COLL) begin
      rval = {12'h000, coll_r};
    end else if (s_axi_araddr == `OFF_IRQ_STAT) begin
      rval = {12'h000, stat_r};
    end else if (s_axi_araddr == `OFF_IRQ_MASK) begin
      rval = {12'h000, mask_r};
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (s_axi_araddr == 12'(`OFF_CTRL0 + i * `OFF_CTRL_STRIDE)) begin
          rval = ctrl_r[i];
        end else if (s_axi_araddr == 12'(`OFF_CNT0 + i * `OFF_CTRL_STRIDE)) begin
          rval = cnt_r[i];
        end else if (s_axi_araddr == 12'(`OFF_RAMA0 + i * `OFF_CTRL_STRIDE)) begin
          rval = rama_r[i];
        end else if (s_axi_araddr == 12'(`OFF_PERA0 + i * `OFF_CTRL_STRIDE)) begin
          rval = pera_r[i];
        end
      end
    end
  end
  logic rd_hit;
  always_comb begin
    rd_hit = (s_axi_araddr == `OFF_COLL) || (s_axi_araddr == `OFF_IRQ_STAT) ||
             (s_axi_araddr == `OFF_IRQ_MASK);
    for (int i = 0; i < NCH; i++) begin
      if (s_axi_araddr == 12'(`OFF_CTRL0 + i * `OFF_CTRL_STRIDE) ||
          s_axi_araddr == 12'(`OFF_CNT0 + i * `OFF_CTRL_STRIDE) ||
          s_axi_araddr == 12'(`OFF_RAMA0 + i * `OFF_CTRL_STRIDE) ||
          s_axi_araddr == 12'(`OFF_PERA0 + i * `OFF_CTRL_STRIDE)) begin
        rd_hit = 1'b1;
      end
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rval};
      s_axi_rresp <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // dma_channel_control

// *** include/dma_ctl_defs.svh ***
`ifndef DMA_CTL_DEFS_SVH
`define DMA_CTL_DEFS_SVH
// byte offsets on the register bus
`define OFF_CTRL0 12'h000
`define OFF_CTRL_STRIDE 12'h004
`define OFF_COLL 12'h010
`define OFF_IRQ_STAT 12'h014
`define OFF_IRQ_MASK 12'h018
`define OFF_CNT0 12'h020
`define OFF_RAMA0 12'h030
`define OFF_PERA0 12'h040
// control field positions
`define BIT_ON 15
`define BIT_SIZE 14
`define BIT_DIR 13
`define BIT_HALF 12
`define BIT_NULL_WRITE_SELECT 11
`define CTRL_WMASK 16'hf833
`define CTRL_RST 16'h0000
`define COLL_RST 4'h0
`define ADDR_POSTINC 2'h0
`define ADDR_NOINC 2'h1
`define ADDR_PERIND 2'h2
`define OPM_PP_BIT 1
`define OPM_ONESHOT_BIT 0
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// *** include/dma_ctl_pkg.sv ***
package dma_ctl_pkg;
  typedef struct packed {
    logic channel_on;
    logic byte_size;
    logic ram_to_periph;
    logic half_irq;
    logic null_write_select;
    logic [1:0] addressing_select;
    logic [1:0] op_mode;
  } chan_cfg_type;
  typedef struct packed {
    logic req;
    logic wr;
    logic periph;
    logic byte_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bus_req_type;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_NULL} xfer_state_type;
endpackage

// *** rtl/dma_chan.sv ***
`timescale 1ns/1ps
`include "dma_ctl_defs.svh"
module dma_chan (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // configuration
  input wire dma_ctl_pkg::chan_cfg_type cfg_i,
  input wire logic [15:0] count_i,
  input wire logic [15:0] ram_base_i,
  input wire logic [15:0] periph_addr_i,
  input wire logic restart_i,
  // service request and memory port
  input wire logic trig_i,
  input wire logic grant_i,
  input wire logic [15:0] rdata_i,
  output dma_ctl_pkg::bus_req_type bus_o,
  // events
  output logic half_o,
  output logic done_o,
  output logic busy_o
);
  dma_ctl_pkg::xfer_state_type state_r;
  logic [15:0] idx_r;
  logic [15:0] data_r;
  logic buf_r;
  logic pp_cnt_r;
  logic stopped_r;
  logic pend_r;
  logic [15:0] ram_addr;
  logic [15:0] step;
  logic last;
  logic [15:0] half_pt;
  assign step = cfg_i.byte_size ? 16'h0001 : 16'h0002;
  // byte elements advance one address
  assign ram_addr = ram_base_i + (cfg_i.addressing_select == `ADDR_NOINC ? 16'h0000 :
                    16'(idx_r * step)) + (buf_r ? 16'(count_i * step) : 16'h0000);
  assign last = (idx_r == count_i);
  // block holds count+1 elements, so half is (count+1)/2 of them
  assign half_pt = 16'((17'(count_i) + 17'h00001) >> 1);
  assign busy_o = (state_r != dma_ctl_pkg::ST_IDLE);
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_r <= 1'b0;
    end else if (!cfg_i.channel_on || restart_i) begin
      pend_r <= 1'b0;
    end else if (trig_i) begin
      pend_r <= 1'b1;
    end else if (state_r == dma_ctl_pkg::ST_IDLE && pend_r && !stopped_r) begin
      pend_r <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= dma_ctl_pkg::ST_IDLE;
      data_r <= 16'h0000;
    end else if (!cfg_i.channel_on || restart_i) begin
      state_r <= dma_ctl_pkg::ST_IDLE;
    end else begin
      case (state_r)
        dma_ctl_pkg::ST_IDLE: begin
          if (pend_r && !stopped_r) begin
            state_r <= dma_ctl_pkg::ST_READ;
          end
        end
        dma_ctl_pkg::ST_READ: begin
          if (grant_i) begin
            data_r <= cfg_i.byte_size ? {8'h00, rdata_i[7:0]} : rdata_i;
            state_r <= dma_ctl_pkg::ST_WRITE;
          end
        end
        dma_ctl_pkg::ST_WRITE: begin
          if (grant_i) begin
            state_r <= (cfg_i.null_write_select && !cfg_i.ram_to_periph) ?
                       dma_ctl_pkg::ST_NULL : dma_ctl_pkg::ST_IDLE;
          end
        end
        default: begin
          if (grant_i) begin
            state_r <= dma_ctl_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
  logic elem_done;
  assign elem_done = grant_i && ((state_r == dma_ctl_pkg::ST_NULL) ||
                     (state_r == dma_ctl_pkg::ST_WRITE &&
                      !(cfg_i.null_write_select && !cfg_i.ram_to_periph)));
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idx_r <= 16'h0000;
      buf_r <= 1'b0;
      pp_cnt_r <= 1'b0;
      stopped_r <= 1'b0;
      half_o <= 1'b0;
      done_o <= 1'b0;
    end else if (!cfg_i.channel_on || restart_i) begin
      idx_r <= 16'h0000;
      buf_r <= 1'b0;
      pp_cnt_r <= 1'b0;
      stopped_r <= 1'b0;
      half_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      half_o <= 1'b0;
      done_o <= 1'b0;
      if (elem_done) begin
        if (16'(idx_r + 16'h0001) == half_pt && cfg_i.half_irq) begin
          half_o <= 1'b1;
        end
        if (last) begin
          idx_r <= 16'h0000;
          done_o <= !cfg_i.half_irq;
          if (cfg_i.op_mode[`OPM_PP_BIT]) begin
            buf_r <= ~buf_r;
            if (cfg_i.op_mode[`OPM_ONESHOT_BIT] && pp_cnt_r) begin
              stopped_r <= 1'b1;
            end
            pp_cnt_r <= ~pp_cnt_r;
          end else if (cfg_i.op_mode[`OPM_ONESHOT_BIT]) begin
            stopped_r <= 1'b1;
          end
        end else begin
          idx_r <= 16'(idx_r + 16'h0001);
        end
      end
    end
  end
  always_comb begin
    bus_o = '0;
    bus_o.byte_en = cfg_i.byte_size;
    case (state_r)
      dma_ctl_pkg::ST_READ: begin
        bus_o.req = 1'b1;
        bus_o.periph = !cfg_i.ram_to_periph;
        bus_o.addr = cfg_i.ram_to_periph ? ram_addr : periph_addr_i;
      end
      dma_ctl_pkg::ST_WRITE: begin
        bus_o.req = 1'b1;
        bus_o.wr = 1'b1;
        bus_o.periph = cfg_i.ram_to_periph;
        bus_o.addr = cfg_i.ram_to_periph ? periph_addr_i : ram_addr;
        bus_o.wdata = data_r;
      end
      dma_ctl_pkg::ST_NULL: begin
        bus_o.req = 1'b1;
        bus_o.wr = 1'b1;
        bus_o.periph = 1'b1;
        bus_o.addr = periph_addr_i;
      end
      default: begin
        bus_o.req = 1'b0;
      end
    endcase
  end
endmodule // dma_chan

// *** rtl/dma_bus_arb.sv ***
`timescale 1ns/1ps
module dma_bus_arb #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // channel requests
  input wire dma_ctl_pkg::bus_req_type [NCH-1:0] req_i,
  output logic [NCH-1:0] grant_o,
  // shared port
  output dma_ctl_pkg::bus_req_type bus_o,
  input wire logic ready_i
);
  logic [$clog2(NCH)-1:0] last_r;
  logic [$clog2(NCH)-1:0] sel;
  logic found;
  // round robin so one channel cannot starve the rest
  always_comb begin
    logic [$clog2(NCH)-1:0] c;
    c = '0;
    sel = last_r;
    found = 1'b0;
    for (int i = 1; i <= NCH; i++) begin
      c = ($clog2(NCH))'((int'(last_r) + i) % NCH);
      if (!found && req_i[c].req) begin
        sel = c;
        found = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_r <= '0;
    end else if (found && ready_i) begin
      last_r <= sel;
    end
  end
  always_comb begin
    grant_o = '0;
    bus_o = found ? req_i[sel] : '0;
    if (found && ready_i) begin
      grant_o[sel] = 1'b1;
    end
  end
endmodule // dma_bus_arb

// *** sim/dma_channel_control_asserts.sv ***
`timescale 1ns/1ps
`include "dma_ctl_defs.svh"
module dma_channel_control_asserts (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory port
  input wire dma_ctl_pkg::bus_req_type mem_o,
  input wire logic mem_ready_i
);
  logic armed_r;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // loose on purpose: any write with bit 15 set arms it
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready && s_axi_wdata[15]) begin
      armed_r <= 1'b1;
    end
  end
  idle_until_on_a: assert property (mem_o.req |-> armed_r)
    else $error("memory request before any channel was turned on");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  mem_hold_a: assert property (mem_o.req && !mem_ready_i |=> $stable(mem_o))
    else $error("memory request changed before grant");
  ctrl_gaps_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr < `OFF_COLL |=>
    s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[10:6] == 5'h0 && s_axi_rdata[3:2] == 2'h0)
    else $error("unimplemented control bits read nonzero");
  coll_upper_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == `OFF_COLL |=> s_axi_rdata[31:4] == 28'h0)
    else $error("collision status upper bits nonzero");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h050 |=>
    s_axi_rresp == `AXI_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  cover property (mem_o.req && mem_ready_i && mem_o.wr && mem_o.periph);
  cover property (mem_o.req && !mem_ready_i);
  cover property (s_axi_rvalid && s_axi_rresp == `AXI_SLVERR);
endmodule // dma_channel_control_asserts
bind dma_channel_control dma_channel_control_asserts dma_channel_control_asserts_i (
  .core_clk_i, .resetn_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .mem_o, .mem_ready_i
);

// *** sim/mem_model.sv ***
`timescale 1ns/1ps
module mem_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // memory port
  input wire dma_ctl_pkg::bus_req_type mem_i,
  input wire logic slow_i,
  output logic ready_o,
  output logic [15:0] rdata_o
);
  logic [1:0] wait_r;
  logic [15:0] noise_r;
  // one grant per request, after 0 to 3 idle cycles when slow
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ready_o <= 1'b0;
      wait_r <= 2'h0;
    end else if (ready_o || !mem_i.req) begin
      ready_o <= 1'b0;
      wait_r <= slow_i ? 2'($urandom) : 2'h0;
    end else if (wait_r == 2'h0) begin
      ready_o <= 1'b1;
    end else begin
      wait_r <= wait_r - 2'h1;
    end
  end
  // data outside a grant keeps moving so stale reads show up
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      noise_r <= 16'h0;
    end else begin
      noise_r <= noise_r + 16'h1357;
    end
  end
  assign rdata_o = (ready_o && !mem_i.wr) ? (mem_i.addr ^ 16'h5a5a) : noise_r;
endmodule // mem_model

// *** sim/test_dma_channel_control.sv ***
`timescale 1ns/1ps
`include "dma_ctl_defs.svh"
module test_dma_channel_control;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] dma_trig_i = 4'h0, periph_collision_i = 4'h0;
  dma_ctl_pkg::bus_req_type mem_o;
  logic mem_ready_i;
  logic [15:0] mem_rdata_i, cfg = 16'h0, ra = 16'h0;
  logic [15:0] cfgs [4] = '{16'h8000, 16'hc011, 16'ha022, 16'hd833};
  logic [33:0] rd_q [$];
  logic [1:0] wr_q [$];
  int n_errors = 0, n_compared = 0, n_rd = 0, n_pw = 0, idx, k;
  always #12.5 core_clk_i = ~core_clk_i;
  dma_channel_control dma_channel_control_i (
    .core_clk_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dma_trig_i, .periph_collision_i, .mem_o, .mem_ready_i, .mem_rdata_i, .irq_o
  );
  mem_model mem_model_i (.core_clk_i, .resetn_i, .mem_i(mem_o), .slow_i(slow),
    .ready_o(mem_ready_i), .rdata_o(mem_rdata_i));
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk_i);
    wr_q.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge core_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge core_clk_i);
    rd_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge core_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
  endtask
  // one trigger edge per element, then wait for the element to finish
  task automatic elem(input int n);
    int r0;
    repeat (n) begin
      @(posedge core_clk_i);
      dma_trig_i[0] <= 1'b1;
      r0 = n_rd;
      @(posedge core_clk_i);
      dma_trig_i[0] <= 1'b0;
      for (int t = 0; t < 40 && (n_rd == r0 || mem_o.req); t++) @(posedge core_clk_i);
    end
    #1;
  endtask
  always @(posedge core_clk_i) begin
    if (s_axi_rvalid && s_axi_rready)
      check("read data", rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      check("write response", wr_q.pop_front(), s_axi_bresp);
    if (mem_o.req && mem_ready_i) begin
      idx = mem_o.wr ? n_rd - 1 : n_rd;
      check("element size", cfg[`BIT_SIZE], mem_o.byte_en);
      if (!mem_o.periph && idx < 4)
        check("ram address", 16'h0100 + (cfg[5:4] == `ADDR_NOINC ? 16'h0 :
          16'(idx) * (cfg[`BIT_SIZE] ? 16'h1 : 16'h2)), mem_o.addr);
      if (!mem_o.wr)
        check("read source", !cfg[`BIT_DIR], mem_o.periph);
      if (!mem_o.wr)
        ra = mem_rdata_i;
      else
        check("write data", (mem_o.periph == cfg[`BIT_DIR]) ?
          (cfg[`BIT_SIZE] ? {8'h0, ra[7:0]} : ra) : 16'h0, mem_o.wdata);
      n_rd += int'(!mem_o.wr);
      n_pw += int'(mem_o.wr && mem_o.periph);
    end
  end
  initial begin
    #500000;
    n_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(85));
    repeat (6) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd(`OFF_CTRL0, 34'h0);
    rd(`OFF_COLL, 34'h0);
    rd(12'h0fc, {`AXI_SLVERR, 32'h0});
    wr(12'h0fc, 32'h0, `AXI_SLVERR);
    wr(`OFF_CTRL_STRIDE, 32'hffff_ffff, `AXI_OKAY);
    rd(`OFF_CTRL_STRIDE, {18'h0, `CTRL_WMASK});
    wr(`OFF_CTRL_STRIDE, 32'h0, `AXI_OKAY);
    @(posedge core_clk_i);
    periph_collision_i <= 4'h4;
    @(posedge core_clk_i);
    periph_collision_i <= 4'h0;
    repeat (4) @(posedge core_clk_i);
    rd(`OFF_COLL, 34'h4);
    wr(`OFF_COLL, 32'h0, `AXI_OKAY);
    rd(`OFF_COLL, 34'h4);
    wr(12'h008, 32'h8000, `AXI_OKAY);
    rd(`OFF_COLL, 34'h0);
    wr(12'h008, 32'h0, `AXI_OKAY);
    wr(`OFF_IRQ_MASK, 32'h1, `AXI_OKAY);
    foreach (cfgs[i]) begin
      cfg = cfgs[i];
      slow <= i[0];
      n_rd = 0;
      n_pw = 0;
      wr(`OFF_CNT0, 32'h3, `AXI_OKAY);
      wr(`OFF_RAMA0, 32'h0100, `AXI_OKAY);
      wr(`OFF_PERA0, 32'h0800, `AXI_OKAY);
      wr(`OFF_CTRL0, {16'h0, cfg}, `AXI_OKAY);
      rd(`OFF_CTRL0, {18'h0, cfg});
      elem(2);
      check("half block irq", cfg[`BIT_HALF], irq_o);
      elem(cfg[1:0] == 2'h3 ? 6 : 2);
      check("full block irq", 1'b1, irq_o);
      check("periph writes", (cfg[`BIT_DIR] || cfg[`BIT_NULL_WRITE_SELECT]) ? n_rd : 0, n_pw);
      k = n_rd;
      elem(1);
      check("after block", k + int'(!cfg[0]), n_rd);
      rd(`OFF_IRQ_STAT, 34'h1);
      wr(`OFF_IRQ_MASK, 32'h0, `AXI_OKAY);
      check("masked irq", 1'b0, irq_o);
      wr(`OFF_IRQ_MASK, 32'h1, `AXI_OKAY);
      check("unmasked irq", 1'b1, irq_o);
      wr(`OFF_IRQ_STAT, 32'h1, `AXI_OKAY);
      check("cleared irq", 1'b0, irq_o);
      wr(`OFF_CTRL0, 32'h0, `AXI_OKAY);
    end
    finish_test();
  end
endmodule // test_dma_channel_control
